/* File: hw/ldc_pkg.sv */
// Purpose: shared constants and types of the led pulse dimming control
// Assumes: mclk at 50 MHz
// Notes: times are given in their own unit and turned into cycles here
package ldc_pkg;
    localparam int CLK_PERIOD_NS = 20;
    localparam int PULSE_MIN_NS = 500;
    localparam int PULSE_MAX_NS = 250000;
    localparam int SHDN_NS = 2500000;
    // least time rounds up, longest time rounds down
    localparam int PULSE_MIN_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_MAX_CYC = PULSE_MAX_NS / CLK_PERIOD_NS;
    localparam int SHDN_CYC = (SHDN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOW_CNT_W = 14;
    localparam int SHDN_CNT_W = 17;
    localparam int STEP_W = 5;
    localparam int LEVEL_W = 6;
    localparam logic [LEVEL_W-1:0] FULL_LEVEL = 6'h20;
    localparam logic [STEP_W-1:0] STEP_RESET = 5'h00;
    localparam int TEMP_W = 9;
    localparam int DERATE_START_C = 43;
    localparam int DERATE_PERMILLE_PER_C = 17;
    localparam int PERMILLE_FULL = 1000;
    localparam int TSHDN_C = 160;
    localparam int TSHDN_HYST_C = 20;
    localparam int MV_W = 12;
    localparam logic [MV_W-1:0] MV_1500 = 12'h5dc;
    localparam logic [MV_W-1:0] MV_1800 = 12'h708;
    localparam logic [MV_W-1:0] MV_1900 = 12'h76c;
    localparam logic [MV_W-1:0] MV_2500 = 12'h9c4;
    localparam logic [MV_W-1:0] MV_2600 = 12'ha28;
    localparam logic [MV_W-1:0] MV_2800 = 12'haf0;
    localparam logic [MV_W-1:0] MV_2900 = 12'hb54;
    localparam logic [MV_W-1:0] MV_3000 = 12'hbb8;
    localparam logic [MV_W-1:0] MV_3300 = 12'hce4;
    // synchroniser bit positions
    localparam int SY_MAIN_A = 0;
    localparam int SY_MAIN_B = 1;
    localparam int SY_FLASH = 2;
    localparam int SY_REG_EN = 3;
    localparam int SY_VA_HI = 4;
    localparam int SY_VA_LO = 5;
    localparam int SY_VB_HI = 6;
    localparam int SY_VB_LO = 7;
    localparam int SY_CATH_LOW = 8;
    localparam int SY_VIN_OUT = 9;
    localparam int SY_VIN_TWO3 = 10;
    localparam int SY_OUT_CHG = 11;
    localparam int SY_CATH_REG = 12;
    localparam int SY_W = 13;
    typedef enum logic [1:0] {
        SEL_SUPPLY = 2'h0,
        SEL_OPEN = 2'h1,
        SEL_GROUND = 2'h2
    } ldc_sel_type;
    typedef enum logic [1:0] {
        PUMP_1X = 2'h0,
        PUMP_1P5X = 2'h1,
        PUMP_2X = 2'h2
    } ldc_pump_type;
    typedef enum logic [2:0] {
        MS_IDLE = 3'h0,
        MS_CHARGE = 3'h1,
        MS_1X = 3'h3,
        MS_1P5X = 3'h2,
        MS_2X = 3'h6
    } ldc_mstate_type;
    typedef enum logic [1:0] {
        CH_OFF = 2'h0,
        CH_HIGH = 2'h1,
        CH_LOW = 2'h3
    } ldc_chstate_type;
    // tri-level pin: high comparator wins, neither means open
    function automatic ldc_sel_type ldc_tri_decode(input logic hi, input logic lo);
        ldc_tri_decode = hi ? SEL_SUPPLY : (lo ? SEL_GROUND : SEL_OPEN);
    endfunction
endpackage

/* File: hw/ldc_chan_if.sv */
// Purpose: carrier between the top and one dimming channel
// Assumes: all signals on mclk
// Notes: ctl side drives enable and force_off
`timescale 1ns/1ps
interface ldc_chan_if;
    import ldc_pkg::*;
    logic enable;
    logic force_off;
    logic on;
    logic [STEP_W-1:0] step;
    logic [LEVEL_W-1:0] level;
    modport ctl (output enable, output force_off, input on, input step, input level);
    modport chan (input enable, input force_off, output on, output step, output level);
endinterface

/* File: hw/ldc_dim_chan.sv */
// Purpose: one single-wire pulse dimming channel
// Assumes: enable already synchronised and combined
// Notes: low longer than the longest pulse turns the group off
`timescale 1ns/1ps
module ldc_dim_chan #(
    parameter logic [ldc_pkg::LOW_CNT_W-1:0] MAX_CYC = 14'h30d4
) (
    input wire logic mclk,
    input wire logic rst_n,
    ldc_chan_if.chan ch
);
    import ldc_pkg::*;
    localparam logic [LOW_CNT_W-1:0] MIN_CYC = LOW_CNT_W'(PULSE_MIN_CYC);
    localparam logic [LOW_CNT_W-1:0] ONE = 14'h0001;

    ldc_chstate_type state_ff, nxt_state;
    logic [LOW_CNT_W-1:0] low_cnt_ff, nxt_low_cnt;
    logic [STEP_W-1:0] step_ff, nxt_step;
    logic [LEVEL_W-1:0] level_ff;
    wire logic pulse_ok = low_cnt_ff >= MIN_CYC;
    wire logic low_too_long = low_cnt_ff >= MAX_CYC;

    always_comb begin
        nxt_state = state_ff;
        nxt_low_cnt = low_cnt_ff;
        nxt_step = step_ff;
        case (state_ff)
            CH_OFF: begin
                if (ch.enable) begin
                    nxt_state = CH_HIGH;
                    nxt_step = STEP_RESET;
                end
            end
            CH_HIGH: begin
                if (!ch.enable) begin
                    nxt_state = CH_LOW;
                    nxt_low_cnt = ONE;
                end
            end
            CH_LOW: begin
                if (ch.enable) begin
                    nxt_state = CH_HIGH;
                    if (pulse_ok) begin
                        nxt_step = step_ff + 5'h01;
                    end
                end else if (low_too_long) begin
                    nxt_state = CH_OFF;
                end else begin
                    nxt_low_cnt = low_cnt_ff + ONE;
                end
            end
            default: nxt_state = CH_OFF;
        endcase
        if (ch.force_off) begin
            nxt_state = CH_OFF;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_ff <= CH_OFF;
            low_cnt_ff <= '0;
            step_ff <= STEP_RESET;
            level_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            low_cnt_ff <= nxt_low_cnt;
            step_ff <= nxt_step;
            level_ff <= FULL_LEVEL - {1'b0, nxt_step}; // off is gated at the top
        end
    end

    assign ch.on = state_ff != CH_OFF;
    assign ch.step = step_ff;
    assign ch.level = level_ff;
endmodule

/* File: hw/ldc_top.sv */
// Purpose: control logic of a charge-pump white led driver
// Assumes: pins and analog comparators are asynchronous, die temperature is
//   a settled on-chip code on mclk
// Notes: levels are in 32nds of the programmed current, derating in permille
`timescale 1ns/1ps
module ldc_top #(
    parameter logic [ldc_pkg::SHDN_CNT_W-1:0] SHDN_CYCLES = ldc_pkg::SHDN_CNT_W'(ldc_pkg::SHDN_CYC),
    parameter logic [ldc_pkg::LOW_CNT_W-1:0] PULSE_MAX_CYCLES =
        ldc_pkg::LOW_CNT_W'(ldc_pkg::PULSE_MAX_CYC),
    parameter logic VARIANT_B = 1'b0
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic main_enable_a,
    input wire logic main_enable_b,
    input wire logic flash_enable,
    input wire logic regulator_enable,
    input wire logic voltage_select_a_hi,
    input wire logic voltage_select_a_lo,
    input wire logic voltage_select_b_hi,
    input wire logic voltage_select_b_lo,
    input wire logic cathode_low,
    input wire logic vin_above_out,
    input wire logic vin_above_two_thirds,
    input wire logic out_charged,
    input wire logic cathode_in_reg,
    input wire logic signed [ldc_pkg::TEMP_W-1:0] die_temp_c,
    output logic main_led_sinks_on,
    output logic [ldc_pkg::LEVEL_W-1:0] main_level,
    output logic flash_led_sinks_on,
    output logic [ldc_pkg::LEVEL_W-1:0] flash_level,
    output logic [9:0] current_limit_permille,
    output logic shutdown,
    output logic supply_isolate,
    output logic out_pulldown,
    output logic thermal_shutdown,
    output ldc_pkg::ldc_pump_type pump_mode,
    output logic pump_active,
    output logic charge_ramp,
    output logic soft_start,
    output ldc_pkg::ldc_sel_type voltage_select_a_code,
    output ldc_pkg::ldc_sel_type voltage_select_b_code,
    output logic [ldc_pkg::MV_W-1:0] regulator_a_out_mv,
    output logic [ldc_pkg::MV_W-1:0] regulator_b_out_mv,
    output logic regulator_active
);
    import ldc_pkg::*;

    localparam logic [SHDN_CNT_W-1:0] SHDN_ONE = 17'h00001;
    localparam logic signed [TEMP_W:0] T_DERATE = 10'(DERATE_START_C);
    localparam logic signed [TEMP_W:0] T_SHDN = 10'(TSHDN_C);
    localparam logic signed [TEMP_W:0] T_RESTART = 10'(TSHDN_C - TSHDN_HYST_C);
    localparam logic [13:0] PERMILLE_STEP = 14'(DERATE_PERMILLE_PER_C);
    localparam logic [13:0] PERMILLE_TOP = 14'(PERMILLE_FULL);

    // two-stage synchroniser for every asynchronous input
    logic [SY_W-1:0] sync1_ff;
    logic [SY_W-1:0] sync2_ff;
    wire logic [SY_W-1:0] raw_in = {
        cathode_in_reg, out_charged, vin_above_two_thirds, vin_above_out,
        cathode_low, voltage_select_b_lo, voltage_select_b_hi,
        voltage_select_a_lo, voltage_select_a_hi, regulator_enable,
        flash_enable, main_enable_b, main_enable_a
    };

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= raw_in;
            sync2_ff <= sync1_ff;
        end
    end

    wire logic en_a = sync2_ff[SY_MAIN_A];
    wire logic en_b = sync2_ff[SY_MAIN_B];
    wire logic en_f = sync2_ff[SY_FLASH];
    wire logic reg_en = sync2_ff[SY_REG_EN];
    wire logic cath_low = sync2_ff[SY_CATH_LOW];
    wire logic vin_out = sync2_ff[SY_VIN_OUT];
    wire logic vin_two3 = sync2_ff[SY_VIN_TWO3];
    wire logic out_chg = sync2_ff[SY_OUT_CHG];
    wire logic cath_reg = sync2_ff[SY_CATH_REG];

    // main pair: both high is high, both low is low, a split keeps the last level
    logic main_en_ff;
    wire logic main_both_hi = en_a & en_b;
    wire logic main_both_lo = ~en_a & ~en_b;
    wire logic nxt_main_en = main_both_hi ? 1'b1 : (main_both_lo ? 1'b0 : main_en_ff);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            main_en_ff <= 1'b0;
        end else begin
            main_en_ff <= nxt_main_en;
        end
    end

    // shutdown after both main enables and the flash enable stay low long enough
    logic [SHDN_CNT_W-1:0] shdn_cnt_ff;
    logic shdn_ff;
    wire logic all_low = ~en_a & ~en_b & ~en_f;
    wire logic shdn_reach = shdn_cnt_ff >= SHDN_CYCLES - SHDN_ONE;
    wire logic [SHDN_CNT_W-1:0] nxt_shdn_cnt =
        !all_low ? '0 : (shdn_reach ? shdn_cnt_ff : shdn_cnt_ff + SHDN_ONE);
    wire logic nxt_shdn = all_low & (shdn_ff | shdn_reach);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            shdn_cnt_ff <= '0;
            shdn_ff <= 1'b0;
        end else begin
            shdn_cnt_ff <= nxt_shdn_cnt;
            shdn_ff <= nxt_shdn;
        end
    end

    // thermal shutdown with hysteresis
    logic tshdn_ff;
    wire logic signed [TEMP_W:0] temp_x = {die_temp_c[TEMP_W-1], die_temp_c};
    wire logic hot = temp_x >= T_SHDN;
    wire logic cooled = temp_x <= T_RESTART;
    wire logic nxt_tshdn = tshdn_ff ? ~cooled : hot;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tshdn_ff <= 1'b0;
        end else begin
            tshdn_ff <= nxt_tshdn;
        end
    end

    // derating of the current limit above the start temperature
    logic [9:0] limit_ff;
    wire logic signed [TEMP_W:0] over_t = temp_x - T_DERATE;
    wire logic [13:0] over_mag = over_t[TEMP_W] ? 14'h0000 : 14'({1'b0, over_t[TEMP_W-1:0]});
    wire logic [13:0] reduce = 14'(over_mag * PERMILLE_STEP);
    wire logic [13:0] limit_wide = (reduce >= PERMILLE_TOP) ? 14'h0000 : PERMILLE_TOP - reduce;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            limit_ff <= 10'(PERMILLE_FULL);
        end else begin
            limit_ff <= limit_wide[9:0];
        end
    end

    // the two dimming channels
    ldc_chan_if main_ch ();
    ldc_chan_if flash_ch ();

    assign main_ch.enable = main_en_ff;
    assign main_ch.force_off = shdn_ff;
    assign flash_ch.enable = en_f;
    assign flash_ch.force_off = shdn_ff;

    ldc_dim_chan #(
        .MAX_CYC(PULSE_MAX_CYCLES)
    ) u_main (
        .mclk(mclk),
        .rst_n(rst_n),
        .ch(main_ch.chan)
    );

    ldc_dim_chan #(
        .MAX_CYC(PULSE_MAX_CYCLES)
    ) u_flash (
        .mclk(mclk),
        .rst_n(rst_n),
        .ch(flash_ch.chan)
    );

    wire logic leds_allowed = ~shdn_ff & ~tshdn_ff;
    wire logic pump_req = (main_ch.on | flash_ch.on) & leds_allowed;

    // pump mode sequencing
    ldc_mstate_type mstate_ff, nxt_mstate;
    logic soft_ff, nxt_soft;

    always_comb begin
        nxt_mstate = mstate_ff;
        nxt_soft = soft_ff;
        case (mstate_ff)
            MS_IDLE: begin
                if (pump_req) begin
                    nxt_mstate = MS_CHARGE;
                    nxt_soft = 1'b1;
                end
            end
            MS_CHARGE: begin
                if (out_chg) begin
                    if (vin_out) begin
                        nxt_mstate = MS_1X;
                        nxt_soft = 1'b0;
                    end else if (vin_two3) begin
                        nxt_mstate = MS_1P5X;
                    end else begin
                        nxt_mstate = MS_2X;
                    end
                end
            end
            MS_1X: begin
                if (cath_low) begin
                    nxt_mstate = MS_1P5X;
                end
            end
            MS_1P5X: begin
                if (vin_out) begin
                    nxt_mstate = MS_1X;
                end else if (cath_low) begin
                    nxt_mstate = MS_2X;
                end
            end
            MS_2X: begin
                if (vin_two3) begin
                    nxt_mstate = MS_1P5X;
                end
            end
            default: nxt_mstate = MS_IDLE;
        endcase
        if (soft_ff && cath_reg && mstate_ff != MS_CHARGE) begin
            nxt_soft = 1'b0;
        end
        if (!pump_req) begin
            nxt_mstate = MS_IDLE;
            nxt_soft = 1'b0;
        end
    end

    ldc_pump_type mode_ff;
    wire ldc_pump_type nxt_mode =
        (nxt_mstate == MS_2X) ? PUMP_2X : ((nxt_mstate == MS_1P5X) ? PUMP_1P5X : PUMP_1X);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mstate_ff <= MS_IDLE;
            soft_ff <= 1'b0;
            mode_ff <= PUMP_1X;
        end else begin
            mstate_ff <= nxt_mstate;
            soft_ff <= nxt_soft;
            mode_ff <= nxt_mode;
        end
    end

    // regulator voltage selection, followed while disabled and held while on
    ldc_sel_type sel_a_ff, sel_b_ff;
    wire ldc_sel_type dec_a = ldc_tri_decode(sync2_ff[SY_VA_HI], sync2_ff[SY_VA_LO]);
    wire ldc_sel_type dec_b = ldc_tri_decode(sync2_ff[SY_VB_HI], sync2_ff[SY_VB_LO]);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sel_a_ff <= SEL_OPEN;
            sel_b_ff <= SEL_OPEN;
        end else if (!reg_en) begin
            sel_a_ff <= dec_a;
            sel_b_ff <= dec_b;
        end
    end // no update path while the regulator is enabled

    function automatic logic [2*MV_W-1:0] volt_pair(input ldc_sel_type a,
                                                     input ldc_sel_type b,
                                                     input logic var_b);
        logic [3:0] idx;
        idx = 4'({2'h0, a} * 4'h3 + {2'h0, b});
        volt_pair = {MV_2500, MV_1800};
        case (idx)
            4'h0: volt_pair = var_b ? {MV_2800, MV_2600} : {MV_3300, MV_1800};
            4'h1: volt_pair = var_b ? {MV_2800, MV_2800} : {MV_3000, MV_1500};
            4'h2: volt_pair = var_b ? {MV_2900, MV_1500} : {MV_2800, MV_1500};
            4'h3: volt_pair = var_b ? {MV_2600, MV_1900} : {MV_3300, MV_1500};
            4'h4: volt_pair = var_b ? {MV_2600, MV_2600} : {MV_2600, MV_1800};
            4'h5: volt_pair = var_b ? {MV_2800, MV_1900} : {MV_2600, MV_1500};
            4'h6: volt_pair = var_b ? {MV_2900, MV_1800} : {MV_3000, MV_1800};
            4'h7: volt_pair = var_b ? {MV_2900, MV_1900} : {MV_2800, MV_1800};
            4'h8: volt_pair = var_b ? {MV_2900, MV_2900} : {MV_2500, MV_1800};
            default: volt_pair = {MV_2500, MV_1800};
        endcase
    endfunction

    logic [2*MV_W-1:0] volt_ff;
    logic reg_act_ff;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            volt_ff <= '0;
            reg_act_ff <= 1'b0;
        end else begin
            volt_ff <= volt_pair(sel_a_ff, sel_b_ff, VARIANT_B);
            reg_act_ff <= reg_en & ~tshdn_ff;
        end
    end

    // registered led and shutdown outputs
    logic main_on_ff, flash_on_ff, isolate_ff;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            main_on_ff <= 1'b0;
            flash_on_ff <= 1'b0;
            isolate_ff <= 1'b0;
        end else begin
            main_on_ff <= main_ch.on & leds_allowed;
            flash_on_ff <= flash_ch.on & leds_allowed;
            isolate_ff <= shdn_ff;
        end
    end

    // a dimming train that starts right after the first high time avoids
    // a full-brightness flash during soft-start
    assign main_led_sinks_on = main_on_ff;
    assign main_level = main_on_ff ? main_ch.level : 6'h00;
    assign flash_led_sinks_on = flash_on_ff;
    assign flash_level = flash_on_ff ? flash_ch.level : 6'h00;
    assign current_limit_permille = limit_ff;
    assign shutdown = shdn_ff;
    assign supply_isolate = isolate_ff;
    assign out_pulldown = isolate_ff;
    assign thermal_shutdown = tshdn_ff;
    assign pump_mode = mode_ff;
    assign pump_active = (mstate_ff != MS_IDLE) && (mstate_ff != MS_CHARGE);
    assign charge_ramp = mstate_ff == MS_CHARGE;
    assign soft_start = soft_ff;
    assign voltage_select_a_code = sel_a_ff;
    assign voltage_select_b_code = sel_b_ff;
    assign regulator_a_out_mv = volt_ff[2*MV_W-1:MV_W];
    assign regulator_b_out_mv = volt_ff[MV_W-1:0];
    assign regulator_active = reg_act_ff;
endmodule

/* File: tb/ldc_host_model.sv */
// Purpose: host model driving the enable lines
// Assumes: tasks are called from the bench between clock edges
// Notes: both main lines move as one tied wire unless split is used
`timescale 1ns/1ps
module ldc_host_model (
    input wire logic mclk,
    output logic main_enable_a,
    output logic main_enable_b,
    output logic flash_enable
);
    initial begin
        main_enable_a = 1'b0;
        main_enable_b = 1'b0;
        flash_enable = 1'b0;
    end
    // main pair driven together, flash on its own line
    task automatic set_line(input bit fl, input bit v);
        @(negedge mclk);
        if (fl) flash_enable = v;
        else begin
            main_enable_a = v;
            main_enable_b = v;
        end
    endtask
    // one line of the main pair only
    task automatic split(input bit v);
        @(negedge mclk);
        main_enable_a = v;
    endtask
    // low for len cycles, then high again at once
    task automatic pulse(input bit fl, input int len);
        set_line(fl, 1'b0);
        repeat (len - 1) @(negedge mclk);
        set_line(fl, 1'b1);
    endtask
endmodule

/* File: tb/ldc_top_sva.sv */
// Purpose: port checks of the led dimming control
// Assumes: single mclk domain
// Notes: shutdown count follows the bound parameter
`timescale 1ns/1ps
module ldc_top_sva #(
    parameter logic [ldc_pkg::SHDN_CNT_W-1:0] SHDN_CYCLES = 17'h1e848
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic main_enable_a,
    input wire logic main_enable_b,
    input wire logic flash_enable,
    input wire logic signed [ldc_pkg::TEMP_W-1:0] die_temp_c,
    input wire logic main_led_sinks_on,
    input wire logic [ldc_pkg::LEVEL_W-1:0] main_level,
    input wire logic flash_led_sinks_on,
    input wire logic [ldc_pkg::LEVEL_W-1:0] flash_level,
    input wire logic [9:0] current_limit_permille,
    input wire logic shutdown,
    input wire logic supply_isolate,
    input wire logic out_pulldown,
    input wire logic thermal_shutdown,
    input wire ldc_pkg::ldc_pump_type pump_mode,
    input wire logic pump_active,
    input wire ldc_pkg::ldc_sel_type voltage_select_a_code,
    input wire ldc_pkg::ldc_sel_type voltage_select_b_code,
    input wire logic regulator_active
);
    import ldc_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    int low_cnt_ff;
    function automatic logic [9:0] lim(input logic signed [TEMP_W-1:0] t);
        if (t <= 43) return 10'h3e8;
        if (t >= 102) return 10'h000;
        return 10'(1000 - 17 * (t - 43));
    endfunction
    // cycles with all three enable pins low
    always_ff @(posedge mclk) begin
        if (!rst_n || main_enable_a || main_enable_b || flash_enable) low_cnt_ff <= 0;
        else if (low_cnt_ff < 1000000) low_cnt_ff <= low_cnt_ff + 1;
    end
    a_shdn_early: assert property ($rose(shutdown) |-> low_cnt_ff >= SHDN_CYCLES)
        else $error("shutdown too early");
    a_shdn_late: assert property (low_cnt_ff == SHDN_CYCLES + 5 |-> shutdown)
        else $error("shutdown missing");
    a_isolate_follow: assert property (supply_isolate == $past(shutdown) &&
        out_pulldown == $past(shutdown))
        else $error("isolation not after shutdown");
    a_shdn_groups_off: assert property (shutdown |-> !main_led_sinks_on &&
        !flash_led_sinks_on)
        else $error("group on in shutdown");
    a_main_step: assert property (main_led_sinks_on &&
        $past(main_led_sinks_on) && main_level != $past(main_level) |->
        main_level == $past(main_level) - 1 || main_level == 32 && $past(main_level) == 1)
        else $error("main level step wrong");
    a_flash_full: assert property ($rose(flash_led_sinks_on) |->
        flash_level == 32)
        else $error("flash not full at turn on");
    a_sel_hold: assert property (regulator_active |->
        $stable(voltage_select_a_code) && $stable(voltage_select_b_code))
        else $error("selection moved while enabled");
    a_derate_limit: assert property (current_limit_permille == lim($past(die_temp_c)))
        else $error("current limit wrong");
    a_thermal_set: assert property (die_temp_c >= 160 |=> thermal_shutdown)
        else $error("thermal shutdown missing");
    a_thermal_clear: assert property (die_temp_c <= 140 |=> !thermal_shutdown)
        else $error("thermal shutdown stuck");
    a_idle_mode: assert property (!pump_active |-> pump_mode == PUMP_1X)
        else $error("pump mode while idle");
endmodule
bind ldc_top ldc_top_sva #(.SHDN_CYCLES(SHDN_CYCLES)) ldc_top_sva_inst (.*);

/* File: tb/tb_top.sv */
// Purpose: self-checking bench of the led dimming control
// Assumes: short counts, shutdown 200 cycles, longest pulse 100 cycles
// Notes: expected levels come from an integer model of the groups
`timescale 1ns/1ps
module tb_top;
    import ldc_pkg::*;
    localparam int PMAX = 100;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic main_enable_a, main_enable_b, flash_enable, regulator_enable;
    logic voltage_select_a_hi, voltage_select_a_lo, voltage_select_b_hi, voltage_select_b_lo;
    logic cathode_low, vin_above_out, vin_above_two_thirds, out_charged, cathode_in_reg;
    logic signed [TEMP_W-1:0] die_temp_c;
    logic main_led_sinks_on, flash_led_sinks_on, shutdown, supply_isolate, out_pulldown;
    logic thermal_shutdown, pump_active, charge_ramp, soft_start, regulator_active;
    logic [LEVEL_W-1:0] main_level, flash_level;
    logic [9:0] current_limit_permille;
    ldc_pump_type pump_mode;
    ldc_sel_type voltage_select_a_code, voltage_select_b_code;
    logic [MV_W-1:0] regulator_a_out_mv, regulator_b_out_mv;
    int fails = 0;
    int samples_checked = 0;
    int cyc = 0;
    int lvl [2];
    int lim;
    int mva [9] = '{3300, 3000, 2800, 3300, 2600, 2600, 3000, 2800, 2500};
    int mvb [9] = '{1800, 1500, 1500, 1500, 1800, 1500, 1800, 1800, 1800};
    logic [31:0] rng = 32'h00010c39;
    ldc_top #(.SHDN_CYCLES(17'h000c8), .PULSE_MAX_CYCLES(14'h0064)) ldc_top_inst (.*);
    ldc_host_model ldc_host_model_inst (.*);
    always #10 mclk = ~mclk;
    function automatic int rnd(input int lo, input int hi);
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return lo + int'(rng % (hi - lo + 1));
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %0h want %0h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            fails++;
            summarize();
        end
    end
    task automatic grp(input bit g, input int wait_cyc);
        repeat (wait_cyc) @(negedge mclk);
        check(g ? flash_level : main_level, lvl[g]);
        check(g ? flash_led_sinks_on : main_led_sinks_on, lvl[g] != 0);
    endtask
    task automatic turn(input bit g, input bit v);
        ldc_host_model_inst.set_line(g, v);
        lvl[g] = v ? 32 : 0;
        grp(g, v ? 8 : PMAX + 10);
    endtask
    task automatic dim(input bit g, input int n);
        ldc_host_model_inst.pulse(g, n);
        if (n > PMAX) lvl[g] = 32;
        else if (n >= 25) lvl[g] = (lvl[g] == 1) ? 32 : lvl[g] - 1;
        grp(g, 6);
    endtask
    task automatic sel(input int i);
        @(negedge mclk);
        voltage_select_a_hi = (i / 3 == 0);
        voltage_select_a_lo = (i / 3 == 2);
        voltage_select_b_hi = (i % 3 == 0);
        voltage_select_b_lo = (i % 3 == 2);
        repeat (5) @(negedge mclk);
    endtask
    task automatic pump(input logic [4:0] v, input logic [1:0] m);
        {out_charged, vin_above_out, vin_above_two_thirds, cathode_low, cathode_in_reg} = v;
        repeat (6) @(negedge mclk);
        check(pump_mode, m);
    endtask
    initial begin
        regulator_enable = 1'b0;
        {voltage_select_a_hi, voltage_select_a_lo, voltage_select_b_hi, voltage_select_b_lo} = '0;
        {out_charged, vin_above_out, vin_above_two_thirds, cathode_low, cathode_in_reg} = '0;
        die_temp_c = 9'sh019;
        repeat (12) @(negedge mclk);
        rst_n = 1'b1;
        check(current_limit_permille, 1000);
        check(voltage_select_a_code, SEL_OPEN);
        turn(0, 1'b1);
        turn(1, 1'b1);
        ldc_host_model_inst.split(1'b0);
        grp(0, 150);
        ldc_host_model_inst.split(1'b1);
        for (int i = 0; i < 33; i++) dim(0, rnd(25, PMAX));
        for (int i = 0; i < 4; i++) dim(1, rnd(25, PMAX));
        dim(0, 24);
        dim(0, 25);
        dim(0, PMAX);
        dim(0, PMAX + 1);
        turn(1, 1'b0);
        turn(1, 1'b1);
        turn(0, 1'b0);
        turn(1, 1'b0);
        check(shutdown, 1'b0);
        repeat (100) @(negedge mclk);
        check(shutdown, 1'b1);
        check(supply_isolate & out_pulldown, 1'b1);
        turn(1, 1'b1);
        check(shutdown, 1'b0);
        for (int i = 0; i < 9; i++) begin
            sel(i);
            check(voltage_select_a_code, i / 3);
            check(voltage_select_b_code, i % 3);
            check(regulator_a_out_mv, mva[i]);
            check(regulator_b_out_mv, mvb[i]);
        end
        sel(4);
        regulator_enable = 1'b1;
        sel(rnd(0, 8));
        sel(0);
        check({voltage_select_a_code, voltage_select_b_code}, 4'h5);
        check(regulator_a_out_mv, 2600);
        foreach (mva[i]) begin
            @(negedge mclk);
            die_temp_c = 9'(40 + i * 8);
            lim = 1000 - 17 * (32 + i * 8 - 35);
            lim = (i * 8 + 40 <= 43) ? 1000 : ((lim < 0) ? 0 : lim);
            repeat (3) @(negedge mclk);
            check(current_limit_permille, lim);
        end
        die_temp_c = 9'sh0a0;
        repeat (3) @(negedge mclk);
        check({thermal_shutdown, regulator_active}, 2'h2);
        die_temp_c = 9'sh08d;
        repeat (3) @(negedge mclk);
        check(thermal_shutdown, 1'b1);
        die_temp_c = 9'sh08c;
        repeat (3) @(negedge mclk);
        check({thermal_shutdown, regulator_active}, 2'h1);
        pump(5'b00000, PUMP_1X);
        check({charge_ramp, soft_start, pump_active}, 3'h6);
        pump(5'b10100, PUMP_1P5X);
        check(soft_start, 1'b1);
        pump(5'b10010, PUMP_2X);
        pump(5'b10101, PUMP_1P5X);
        check(soft_start, 1'b0);
        pump(5'b11001, PUMP_1X);
        turn(1, 1'b0);
        turn(1, 1'b1);
        check({soft_start, pump_active}, 2'h1);
        summarize();
    end
endmodule
